// [hw/eeprom_cmd_pkg.sv]
package eeprom_cmd_pkg;

  // Core clock period and the self-timed program cycle length
  localparam int CLK_PERIOD_NS = 20;
  localparam int PROG_TIME_US = 3000;
  // Longest time, so the division rounds down
  localparam int PROG_CYCLES_DFLT = (PROG_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int CNT_W = 18;

  // Field widths for the two organizations
  localparam int ADDR_BITS_X8 = 7;
  localparam int ADDR_BITS_X16 = 6;
  localparam int DATA_BITS_X8 = 8;
  localparam int DATA_BITS_X16 = 16;
  localparam int WORD_AW = 6;
  localparam int WORD_COUNT = 64;
  localparam int BITCNT_W = 5;

  // Two-bit opcodes following the start bit
  localparam logic [1:0] OPC_EXT = 2'h0;
  localparam logic [1:0] OPC_WRITE = 2'h1;
  localparam logic [1:0] OPC_READ = 2'h2;
  localparam logic [1:0] OPC_ERASE = 2'h3;

  // Leading two address bits under the extended opcode
  localparam logic [1:0] EXT_DISABLE = 2'h0;
  localparam logic [1:0] EXT_WRITE_ALL = 2'h1;
  localparam logic [1:0] EXT_ERASE_ALL = 2'h2;
  localparam logic [1:0] EXT_ENABLE = 2'h3;

  // Erased pattern and reset values
  localparam logic [15:0] ERASED_WORD = 16'hffff;
  localparam logic [1:0] BE_BOTH = 2'h3;
  localparam logic [1:0] BE_LOW = 2'h1;
  localparam logic [1:0] BE_HIGH = 2'h2;
  localparam logic PROG_EN_RESET = 1'b0;

  // Command decoder states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_OPCODE,
    ST_ADDR,
    ST_DATA,
    ST_RD_WAIT,
    ST_RD_LOAD,
    ST_RD_OUT,
    ST_HOLD
  } dec_state_t;

endpackage

// [hw/pin_sync.sv]
`timescale 1ns/1ps
`default_nettype none

// Two-stage synchronizer for each asynchronous pin
module pin_sync #(
  parameter int W = 4
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_out
);

  logic [W-1:0] meta_q; // First stage, read only by the second stage

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      // Each bit passes two flops before any logic sees it
      always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
          meta_q[g] <= 1'b0;
          pin_out[g] <= 1'b0;
        end else begin
          meta_q[g] <= pin_in[g];
          pin_out[g] <= meta_q[g];
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

// [hw/word_store.sv]
`timescale 1ns/1ps
`default_nettype none

// 64 x 16 array with byte-lane write enables and registered read data
module word_store
  import eeprom_cmd_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [eeprom_cmd_pkg::WORD_AW-1:0] rd_addr,
  output logic [15:0] rd_data,
  input wire logic wr_en,
  input wire logic [eeprom_cmd_pkg::WORD_AW-1:0] wr_addr,
  input wire logic [15:0] wr_data,
  input wire logic [1:0] wr_be
);

  // Array has no reset, like the cells it stands for
  logic [15:0] mem_q [WORD_COUNT];

  // Byte lanes let the x8 organization touch half a word
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < 2; i++) begin
      if (wr_en && wr_be[i]) begin
        mem_q[wr_addr][i*8 +: 8] <= wr_data[i*8 +: 8];
      end
    end
  end

  // Read data always comes from a flop, one cycle after the address
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_data <= 16'h0000;
    end else begin
      rd_data <= mem_q[rd_addr];
    end
  end

endmodule

`default_nettype wire

// [hw/eeprom_cmd.sv]
// What this block does
// - Select rise, start bit one, opcode, address
// - Opcode 10 reads addressed location
// - Opcode 01 writes data word to location
// - Opcode 11 erases location to all ones
// - Extended 11 enables programming
// - Extended 10 erases whole array
// - Extended 01 writes one word everywhere
// - Extended 00 disables programming
// - Read data changes on clock rising edges
// - Read outputs dummy zero, then word
// - Reset leaves programming disabled
// - Enable persists until disable command
// - Program commands ignored while disabled
// - Erase starts after full address
// - Write starts after last data bit
// - Select high shows busy zero, ready one
// - No status if select rises after cycle
// - Read works whether enabled or not
// - x8 uses 7+8 bits, x16 6+16
// - Width select high means 16-bit words
// - Output released while select low
`timescale 1ns/1ps
`default_nettype none

module eeprom_cmd
  import eeprom_cmd_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = eeprom_cmd_pkg::PROG_CYCLES_DFLT
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic chip_select,
  input wire logic shift_clock,
  input wire logic serial_in,
  input wire logic word_width_select,
  output logic serial_out,
  output logic serial_out_oe
);
  import eeprom_cmd_pkg::*;

  // Synchronized pins
  logic [3:0] pins_s;
  logic cs_s, sk_s, di_s, org_s;
  logic sk_prev_q, cs_prev_q; // Edge history
  logic sk_rise, cs_rise;

  // Decoder state
  dec_state_t st_q, st_d;
  logic [BITCNT_W-1:0] bitcnt_q, bitcnt_d;
  logic [1:0] opc_q, opc_d;
  logic [6:0] addr_q, addr_d;
  logic [15:0] data_q, data_d;
  logic [15:0] shreg_q, shreg_d; // Read shifter
  logic wide_q, wide_d; // Organization caught at the start bit
  logic drive_q, drive_d; // Read data owns the output
  logic ev_read, ev_enable, ev_disable, ev_prog, ev_erase, ev_all;
  logic [1:0] ext_code;

  // Program cycle state
  logic prog_en_q, prog_en_d;
  logic busy_q, busy_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic all_q, all_d;
  logic [15:0] pword_q, pword_d;
  logic [1:0] pbe_q, pbe_d;
  logic [WORD_AW-1:0] paddr_q, paddr_d;
  logic show_q, show_d; // Status display active

  // Output flops
  logic out_d, oe_d;

  // Memory ports
  logic [15:0] rd_data;
  logic wr_en;
  logic [WORD_AW-1:0] wr_addr, rd_addr;

  // Field lengths per organization, used in several places
  function automatic logic [BITCNT_W-1:0] addr_last(input logic wide);
    addr_last = wide ? BITCNT_W'(ADDR_BITS_X16 - 1) : BITCNT_W'(ADDR_BITS_X8 - 1);
  endfunction

  function automatic logic [BITCNT_W-1:0] data_last(input logic wide);
    data_last = wide ? BITCNT_W'(DATA_BITS_X16 - 1) : BITCNT_W'(DATA_BITS_X8 - 1);
  endfunction

  function automatic logic [WORD_AW-1:0] word_index(input logic wide, input logic [6:0] a);
    word_index = wide ? a[5:0] : a[6:1];
  endfunction

  pin_sync #(.W(4)) u_sync (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .pin_in({word_width_select, serial_in, shift_clock, chip_select}),
    .pin_out(pins_s)
  );

  assign cs_s = pins_s[0];
  assign sk_s = pins_s[1];
  assign di_s = pins_s[2];
  assign org_s = pins_s[3];
  assign sk_rise = sk_s & ~sk_prev_q;
  assign cs_rise = cs_s & ~cs_prev_q;

  // During a sweep the read port is idle, so it follows the command address
  assign rd_addr = word_index(wide_q, addr_q);
  assign wr_en = busy_q && (all_q ? (cnt_q < CNT_W'(WORD_COUNT)) : (cnt_q == '0));
  assign wr_addr = all_q ? cnt_q[WORD_AW-1:0] : paddr_q;

  word_store u_store (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(pword_q),
    .wr_be(pbe_q)
  );

  // Instruction decoder next state
  always_comb begin
    st_d = st_q;
    bitcnt_d = bitcnt_q;
    opc_d = opc_q;
    addr_d = addr_q;
    data_d = data_q;
    shreg_d = shreg_q;
    wide_d = wide_q;
    drive_d = drive_q;
    ev_read = 1'b0;
    ev_enable = 1'b0;
    ev_disable = 1'b0;
    ev_prog = 1'b0;
    ev_erase = 1'b0;
    ev_all = 1'b0;
    ext_code = 2'h0;
    if (!cs_s) begin
      // Select low throws away any partial command
      st_d = ST_IDLE;
      drive_d = 1'b0;
    end else begin
      unique case (st_q)
        ST_IDLE: begin
          // Zeros before the start bit are skipped; busy blocks new commands
          if (sk_rise && di_s && !busy_q) begin
            st_d = ST_OPCODE;
            bitcnt_d = '0;
            wide_d = org_s;
          end
        end
        ST_OPCODE: begin
          if (sk_rise) begin
            opc_d = {opc_q[0], di_s};
            bitcnt_d = bitcnt_q + 1'b1;
            if (bitcnt_q == BITCNT_W'(1)) begin
              st_d = ST_ADDR;
              bitcnt_d = '0;
            end
          end
        end
        ST_ADDR: begin
          if (sk_rise) begin
            addr_d = {addr_q[5:0], di_s};
            bitcnt_d = bitcnt_q + 1'b1;
            // Don't-care bits still count toward the field
            if (bitcnt_q == addr_last(wide_q)) begin
              ext_code = wide_q ? addr_d[5:4] : addr_d[6:5];
              bitcnt_d = '0;
              st_d = ST_HOLD;
              unique case (opc_q)
                OPC_READ: begin
                  // Reads ignore the programming enable
                  ev_read = 1'b1;
                  drive_d = 1'b1;
                  st_d = ST_RD_WAIT;
                end
                OPC_WRITE: st_d = ST_DATA;
                OPC_ERASE: begin
                  ev_erase = 1'b1;
                  ev_prog = prog_en_q;
                end
                OPC_EXT: begin
                  unique case (ext_code)
                    EXT_ENABLE: ev_enable = 1'b1;
                    EXT_DISABLE: ev_disable = 1'b1;
                    EXT_ERASE_ALL: begin
                      ev_erase = 1'b1;
                      ev_all = 1'b1;
                      ev_prog = prog_en_q;
                    end
                    EXT_WRITE_ALL: st_d = ST_DATA;
                  endcase
                end
              endcase
            end
          end
        end
        ST_DATA: begin
          if (sk_rise) begin
            data_d = {data_q[14:0], di_s};
            bitcnt_d = bitcnt_q + 1'b1;
            if (bitcnt_q == data_last(wide_q)) begin
              ev_all = (opc_q == OPC_EXT);
              ev_prog = prog_en_q;
              st_d = ST_HOLD;
            end
          end
        end
        ST_RD_WAIT: st_d = ST_RD_LOAD; // Array read in flight
        ST_RD_LOAD: begin
          // x8 words are left-aligned so the shifter always leaves MSB first
          if (wide_q) begin
            shreg_d = rd_data;
          end else begin
            shreg_d = {(addr_q[0] ? rd_data[15:8] : rd_data[7:0]), 8'h00};
          end
          bitcnt_d = '0;
          st_d = ST_RD_OUT;
        end
        ST_RD_OUT: begin
          if (sk_rise) begin
            shreg_d = {shreg_q[14:0], 1'b0};
            bitcnt_d = bitcnt_q + 1'b1;
            if (bitcnt_q == data_last(wide_q)) begin
              st_d = ST_HOLD;
            end
          end
        end
        ST_HOLD: st_d = ST_HOLD; // Wait for select to drop
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= ST_IDLE;
      bitcnt_q <= '0;
      opc_q <= 2'h0;
      addr_q <= 7'h00;
      data_q <= 16'h0000;
      shreg_q <= 16'h0000;
      wide_q <= 1'b1;
      drive_q <= 1'b0;
      sk_prev_q <= 1'b0;
      cs_prev_q <= 1'b0;
    end else begin
      st_q <= st_d;
      bitcnt_q <= bitcnt_d;
      opc_q <= opc_d;
      addr_q <= addr_d;
      data_q <= data_d;
      shreg_q <= shreg_d;
      wide_q <= wide_d;
      drive_q <= drive_d;
      sk_prev_q <= sk_s;
      cs_prev_q <= cs_s;
    end
  end

  // Programming enable, self-timed cycle and status display
  always_comb begin
    prog_en_d = prog_en_q;
    busy_d = busy_q;
    cnt_d = cnt_q;
    all_d = all_q;
    pword_d = pword_q;
    pbe_d = pbe_q;
    paddr_d = paddr_q;
    show_d = show_q;
    if (ev_enable) begin
      prog_en_d = 1'b1;
    end else if (ev_disable) begin
      prog_en_d = 1'b0;
    end
    if (busy_q) begin
      cnt_d = cnt_q + 1'b1;
      if (cnt_q == CNT_W'(PROG_CYCLES - 1)) begin
        busy_d = 1'b0;
      end
    end
    if (ev_prog) begin
      // Latch the whole job; the array is written during the busy period
      busy_d = 1'b1;
      cnt_d = '0;
      all_d = ev_all;
      if (ev_erase) begin
        pword_d = ERASED_WORD;
      end else if (wide_q) begin
        pword_d = data_d;
      end else begin
        pword_d = {data_d[7:0], data_d[7:0]};
      end
      if (ev_all || wide_q) begin
        pbe_d = BE_BOTH;
      end else begin
        pbe_d = addr_d[0] ? BE_HIGH : BE_LOW;
      end
      paddr_d = word_index(wide_q, addr_d);
    end
    // Status only if select rises while still busy
    if (!cs_s || (st_q == ST_IDLE && st_d == ST_OPCODE)) begin
      show_d = 1'b0;
    end
    if (cs_rise) begin
      show_d = busy_q;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      prog_en_q <= PROG_EN_RESET;
      busy_q <= 1'b0;
      cnt_q <= '0;
      all_q <= 1'b0;
      pword_q <= 16'h0000;
      pbe_q <= 2'h0;
      paddr_q <= '0;
      show_q <= 1'b0;
    end else begin
      prog_en_q <= prog_en_d;
      busy_q <= busy_d;
      cnt_q <= cnt_d;
      all_q <= all_d;
      pword_q <= pword_d;
      pbe_q <= pbe_d;
      paddr_q <= paddr_d;
      show_q <= show_d;
    end
  end

  // Serial output value and enable
  always_comb begin
    out_d = serial_out;
    if (ev_read) begin
      out_d = 1'b0;
    end else if (st_q == ST_RD_OUT && sk_rise) begin
      out_d = shreg_q[15];
    end
    if (show_d) begin
      out_d = ~busy_d;
    end
    oe_d = cs_s && (show_d || drive_d);
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      serial_out <= 1'b0;
      serial_out_oe <= 1'b0;
    end else begin
      serial_out <= out_d;
      serial_out_oe <= oe_d;
    end
  end

  property p_release_low;
    @(posedge core_clk) disable iff (!reset_n) !cs_s |=> !serial_out_oe;
  endproperty
  a_release_low: assert property (p_release_low) else $error("output driven with select low");

  property p_enable_cause;
    @(posedge core_clk) disable iff (!reset_n) $rose(prog_en_q) |-> $past(ev_enable);
  endproperty
  a_enable_cause: assert property (p_enable_cause) else $error("enable set without command");

  property p_enable_hold;
    @(posedge core_clk) disable iff (!reset_n) (prog_en_q && !ev_disable) |=> prog_en_q;
  endproperty
  a_enable_hold: assert property (p_enable_hold) else $error("enable lost without disable");

  property p_disable_clears;
    @(posedge core_clk) disable iff (!reset_n) ev_disable |=> !prog_en_q;
  endproperty
  a_disable_clears: assert property (p_disable_clears) else $error("disable did not clear");

  property p_prog_guard;
    @(posedge core_clk) disable iff (!reset_n) $rose(busy_q) |-> $past(prog_en_q);
  endproperty
  a_prog_guard: assert property (p_prog_guard) else $error("program while disabled");

  property p_dummy_zero;
    // Only the first cycle needs the enable: a legal select drop may release the wire early
    @(posedge core_clk) disable iff (!reset_n) ev_read |=> (serial_out_oe && !serial_out) ##1 (!serial_out) [*2];
  endproperty
  a_dummy_zero: assert property (p_dummy_zero) else $error("no dummy zero");

  property p_out_on_edge;
    @(posedge core_clk) disable iff (!reset_n) (st_q == ST_RD_OUT && cs_s && !sk_rise && !show_d) |=> $stable(serial_out);
  endproperty
  a_out_on_edge: assert property (p_out_on_edge) else $error("read data moved off edge");

  property p_busy_shows;
    @(posedge core_clk) disable iff (!reset_n) (cs_rise && busy_q && busy_d) |=> (serial_out_oe && !serial_out);
  endproperty
  a_busy_shows: assert property (p_busy_shows) else $error("busy not shown");

  property p_late_select;
    @(posedge core_clk) disable iff (!reset_n) (cs_rise && !busy_q && !drive_d) |=> !serial_out_oe;
  endproperty
  a_late_select: assert property (p_late_select) else $error("status after cycle end");

  property p_write_start;
    @(posedge core_clk) disable iff (!reset_n) ev_prog |=> (busy_q && cnt_q == '0);
  endproperty
  a_write_start: assert property (p_write_start) else $error("program cycle not started");

endmodule

`default_nettype wire

// [sim/eeprom_host.sv]
`timescale 1ns/1ps
`default_nettype none

// Host side of the link: drives select, shift clock and serial data
module eeprom_host (
  input wire logic core_clk,
  input wire logic data_wire,
  output logic chip_select,
  output logic shift_clock,
  output logic serial_in
);
  // Pins start low; the clock stands still between frames
  initial begin
    chip_select = 1'b0;
    shift_clock = 1'b0;
    serial_in = 1'b0;
  end

  // Pins only move at falling core clock edges
  task automatic ticks(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  // Select, then n bits MSB first, then extra clocks that read back
  task automatic frame(input logic [31:0] bits, input int n, input int extra, output logic [31:0] got);
    got = '0;
    chip_select = 1'b1;
    ticks(4);
    for (int i = 0; i < n + extra; i++) begin
      // Every bit gets its own pulse, don't-care ones too
      serial_in = (i < n) ? bits[n-1-i] : 1'b0;
      ticks(4);
      // Sample late in the low phase, where the output has settled
      got = {got[30:0], data_wire};
      shift_clock = 1'b1;
      ticks(4);
      shift_clock = 1'b0;
    end
    ticks(4);
    got = {got[30:0], data_wire};
    deselect();
  endtask

  // Drop select; the data line no longer carries a real bit
  task automatic deselect();
    chip_select = 1'b0;
    shift_clock = 1'b0;
    serial_in = ~serial_in;
    ticks(6);
  endtask

  // Select with no clocking, as done to look at status
  task automatic select_only();
    chip_select = 1'b1;
    ticks(6);
  endtask

  // Look at status and count clocks until ready; bounded
  task automatic status(output logic first, output int cnt);
    select_only();
    first = data_wire;
    cnt = 0;
    while (data_wire !== 1'b1 && cnt < 1000) begin
      ticks(1);
      cnt++;
    end
  endtask
endmodule

`default_nettype wire

// [sim/three_wire_serial_eeprom_cmd_tb.sv]
`timescale 1ns/1ps
`default_nettype none

module three_wire_serial_eeprom_cmd_tb;
  import eeprom_cmd_pkg::*;
  // Short program cycle; must stay above the 64-word sweep
  localparam int PC = 100;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic word_width_select = 1'b1;
  logic chip_select;
  logic shift_clock;
  logic serial_in;
  logic serial_out;
  logic serial_out_oe;
  // No pull on the data wire: an undriven wire shows the inverse, so a sample taken while released fails
  wire logic data_wire = serial_out_oe ? serial_out : ~serial_out;
  int mismatches = 0;
  int checks = 0;
  logic [31:0] got;
  logic first;
  int cnt;

  // 50 MHz core clock
  always #10 core_clk = ~core_clk;

  eeprom_cmd #(.PROG_CYCLES(PC)) i_eeprom_cmd (.core_clk(core_clk), .reset_n(reset_n),
    .chip_select(chip_select), .shift_clock(shift_clock), .serial_in(serial_in),
    .word_width_select(word_width_select), .serial_out(serial_out), .serial_out_oe(serial_out_oe));

  eeprom_host i_eeprom_host (.core_clk(core_clk), .data_wire(data_wire), .chip_select(chip_select),
    .shift_clock(shift_clock), .serial_in(serial_in));

  // Compare and count
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Verdict and end of run
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Instruction images, padded to 32 bits; shift right to drop data
  function automatic logic [31:0] c16(input logic [1:0] opc, input logic [5:0] a, input logic [15:0] d);
    c16 = {7'h0, 1'b1, opc, a, d};
  endfunction

  function automatic logic [31:0] c8(input logic [1:0] opc, input logic [6:0] a, input logic [7:0] d);
    c8 = {14'h0, 1'b1, opc, a, d};
  endfunction

  task automatic send(input logic [31:0] bits, input int n);
    i_eeprom_host.frame(bits, n, 0, got);
  endtask

  // Program command, then select high: busy zero first, ready in time
  task automatic prog(input logic [31:0] bits, input int n);
    send(bits, n);
    i_eeprom_host.status(first, cnt);
    check("busy level", {31'h0, first}, 32'h0);
    if (cnt >= 1000) begin
      check("ready timeout", 32'h1, 32'h0);
      finish_test();
    end
    check("busy length", {31'h0, (cnt > PC / 2 && cnt < PC)}, 32'h1);
    i_eeprom_host.deselect();
  endtask

  // Read w bits; the bit before them must be the dummy zero
  task automatic rd(input logic [31:0] bits, input int n, input int w, input logic [15:0] exp);
    i_eeprom_host.frame(bits, n, w, got);
    check("read data", got & ((32'h2 << w) - 32'h1), {16'h0, exp});
    // The frame ended with select low, so the read must have let go of the wire
    check("read released oe", {31'h0, serial_out_oe}, 32'h0);
  endtask

  task automatic t_program();
    send(c16(OPC_EXT, {EXT_ENABLE, 4'h0}, 16'h0) >> 16, 9);
    prog(c16(OPC_WRITE, 6'h05, 16'h1234), 25);
    // Select raised long after the cycle ended shows nothing
    send(c16(OPC_WRITE, 6'h09, 16'h0f0f), 25);
    repeat (2 * PC) @(negedge core_clk);
    i_eeprom_host.select_only();
    check("late status oe", {31'h0, serial_out_oe}, 32'h0);
    i_eeprom_host.deselect();
    rd(c16(OPC_READ, 6'h09, 16'h0) >> 16, 9, 16, 16'h0f0f);
    prog(c16(OPC_ERASE, 6'h09, 16'h0) >> 16, 9);
    rd(c16(OPC_READ, 6'h09, 16'h0) >> 16, 9, 16, 16'hffff);
    rd(c16(OPC_READ, 6'h05, 16'h0) >> 16, 9, 16, 16'h1234);
    $display("test program done");
  endtask

  task automatic t_protect();
    send(c16(OPC_EXT, {EXT_DISABLE, 4'h0}, 16'h0) >> 16, 9);
    send(c16(OPC_WRITE, 6'h05, 16'habcd), 25);
    i_eeprom_host.select_only();
    check("refused status oe", {31'h0, serial_out_oe}, 32'h0);
    i_eeprom_host.deselect();
    check("released oe", {31'h0, serial_out_oe}, 32'h0);
    rd(c16(OPC_READ, 6'h05, 16'h0) >> 16, 9, 16, 16'h1234);
    // A reset in mid-run must drop a granted enable
    send(c16(OPC_EXT, {EXT_ENABLE, 4'h0}, 16'h0) >> 16, 9);
    reset_n = 1'b0;
    repeat (4) @(negedge core_clk);
    reset_n = 1'b1;
    repeat (4) @(negedge core_clk);
    send(c16(OPC_WRITE, 6'h05, 16'h5555), 25);
    rd(c16(OPC_READ, 6'h05, 16'h0) >> 16, 9, 16, 16'h1234);
    $display("test protect done");
  endtask

  task automatic t_all();
    send(c16(OPC_EXT, {EXT_ENABLE, 4'h0}, 16'h0) >> 16, 9);
    prog(c16(OPC_EXT, {EXT_WRITE_ALL, 4'h0}, 16'h3c5a), 25);
    rd(c16(OPC_READ, 6'h3f, 16'h0) >> 16, 9, 16, 16'h3c5a);
    // Write cut short by select; three zeros lead the next read
    send(c16(OPC_WRITE, 6'h00, 16'h0) >> 8, 17);
    rd(c16(OPC_READ, 6'h00, 16'h0) >> 16, 12, 16, 16'h3c5a);
    prog(c16(OPC_EXT, {EXT_ERASE_ALL, 4'h0}, 16'h0) >> 16, 9);
    rd(c16(OPC_READ, 6'h11, 16'h0) >> 16, 9, 16, 16'hffff);
    $display("test all done");
  endtask

  task automatic t_x8();
    word_width_select = 1'b0;
    prog(c8(OPC_WRITE, 7'h07, 8'ha5), 18);
    prog(c8(OPC_WRITE, 7'h06, 8'h3c), 18);
    rd(c8(OPC_READ, 7'h07, 8'h0) >> 8, 10, 8, 16'h00a5);
    word_width_select = 1'b1;
    // Odd byte address lands in the high byte of word 3, even address in the low byte
    rd(c16(OPC_READ, 6'h03, 16'h0) >> 16, 9, 16, 16'ha53c);
    send(c16(OPC_EXT, {EXT_DISABLE, 4'h0}, 16'h0) >> 16, 9);
    $display("test x8 done");
  endtask

  // Reset for 16 clocks, then the scenarios in turn
  initial begin
    repeat (16) @(negedge core_clk);
    reset_n = 1'b1;
    repeat (4) @(negedge core_clk);
    check("oe after reset", {31'h0, serial_out_oe}, 32'h0);
    t_program();
    t_protect();
    t_all();
    t_x8();
    finish_test();
  end
endmodule

`default_nettype wire
